// ==== pkg/sgb_ff_if.sv ====
// Link between the control core and the feed-forward lag filter
`timescale 1ns/100ps
`default_nettype none
interface sgb_ff_if;
  logic tick;
  logic [12:0] time_const;
  logic signed [16:0] x;
  logic signed [16:0] y;
  modport src (output tick, output time_const, output x, input y);
  modport filt (input tick, input time_const, input x, output y);
endinterface : sgb_ff_if
`default_nettype wire

// ==== pkg/sgb_pkg.sv ====
// Constants, types and helpers for the servo gain select and bias block
// Operation
// - Mapped gain-select input picks second gain set
// - Auto switching conditions met selects second set
// - Auto switching only in position control
// - Auto selection 1 to 3 ignores gain-select input
// - Second gain set suspends online auto-tuning
// - Bias added while residual exceeds bias band
// - Bias speed 0 to 450, zero disables
// - Feed-forward scaled by 0 to 100 percent
// - Feed-forward lag filter, 0 to 6400 units
// - P-switch condition codes 0 to 4, default 4
// - Speed control setting word defaults to 0004
// - Codes 0 to 3 compare quantity, enter P
// - IP loop type switches IP to P
// - Loop type, condition latched at power-up only
// - Loop type 0 PI, 1 IP
// - P control when selected quantity exceeds threshold
// - Auto codes: off, command, deviation, both
`default_nettype none
package sgb_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CTRL_CYCLE_NS = 10000;
  localparam int CTRL_CYCLE_CLKS = (CTRL_CYCLE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   CTRL_CYCLE_NS / CLK_PERIOD_NS;
  localparam logic [9:0] CTRL_CNT_LAST = 10'(CTRL_CYCLE_CLKS - 1);
  localparam logic [9:0] CTRL_CNT_RESET = 10'h000;
  // Setting word nibbles: condition, loop type, auto switching
  localparam int WORD_PCOND_LSB = 0;
  localparam int WORD_LOOP_LSB = 4;
  localparam int WORD_AUTO_LSB = 8;
  localparam logic [15:0] SPEED_WORD_RESET = 16'h0004;
  localparam logic [15:0] BIAS_SPEED_MAX = 16'h01c2;
  localparam logic [15:0] BIAS_BAND_MAX = 16'h00fa;
  localparam logic [15:0] FF_AMOUNT_MAX = 16'h0064;
  localparam logic [15:0] FF_TIME_MAX = 16'h1900;
  // Division by 100 as multiply by 655 and shift by 16
  localparam logic signed [33:0] FF_DIV_MUL = 34'sh0028f;
  localparam int FF_DIV_SHIFT = 16;
  localparam logic [3:0] GAIN_SELECT_INPUT_UNMAPPED = 4'h0;

  typedef enum logic [1:0] {
    MODE_POSITION = 2'b00,
    MODE_SPEED = 2'b01,
    MODE_INT_SPEED = 2'b10,
    MODE_TORQUE = 2'b11
  } sgb_mode_t;

  typedef enum logic [3:0] {
    PCOND_TORQUE = 4'b0000,
    PCOND_SPEED = 4'b0001,
    PCOND_ACCEL = 4'b0010,
    PCOND_DEV = 4'b0011,
    PCOND_NONE = 4'b0100
  } sgb_pcond_t;

  typedef enum logic {
    LOOP_PI = 1'b0,
    LOOP_IP = 1'b1
  } sgb_loop_t;

  typedef enum logic [3:0] {
    AUTO_OFF = 4'b0000,
    AUTO_CMD = 4'b0001,
    AUTO_DEV = 4'b0010,
    AUTO_BOTH = 4'b0011
  } sgb_auto_t;

  typedef enum logic {
    PH_LATCH = 1'b0,
    PH_RUN = 1'b1
  } sgb_phase_t;

  function automatic logic [15:0] sgb_abs(input logic signed [15:0] v);
    sgb_abs = v[15] ? 16'(-v) : 16'(v);
  endfunction : sgb_abs

  function automatic logic [15:0] sgb_sat(input logic [15:0] v,
                                          input logic [15:0] m);
    sgb_sat = (v > m) ? m : v;
  endfunction : sgb_sat
endpackage : sgb_pkg
`default_nettype wire

// ==== rtl/sgb_ff_filter.sv ====
// First-order lag filter for the feed-forward term
`timescale 1ns/100ps
`default_nettype none
module sgb_ff_filter
  import sgb_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Filter link
  sgb_ff_if.filt ff
);
  typedef struct packed {
    logic signed [16:0] y;
  } sgb_filt_state_t;

  sgb_filt_state_t st;
  sgb_filt_state_t next_st;
  logic [3:0] shift;
  logic signed [17:0] diff;

  // Gain 1/2^(msb+1) approximates 1/(T+1) without a divider
  function automatic logic [3:0] sgb_msb(input logic [12:0] v);
    sgb_msb = 4'h0;
    for (int i = 0; i < 13; i++) begin
      if (v[i]) begin
        sgb_msb = 4'(i);
      end
    end
  endfunction : sgb_msb

  always_comb begin
    next_st = st;
    shift = sgb_msb(ff.time_const) + 4'h1;
    diff = 18'(ff.x) - 18'(st.y);
    if (ff.tick) begin
      if (ff.time_const == 13'h0000) begin
        next_st.y = ff.x;
      end else begin
        next_st.y = st.y + 17'(diff >>> shift);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ff.y = st.y;

  AST_FILTER_BYPASS: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    ff.tick && ff.time_const == 13'h0000 |=> ff.y == $past(ff.x))
    else $error("Unfiltered feed-forward did not follow its input");
endmodule : sgb_ff_filter
`default_nettype wire

// ==== rtl/sgb_top.sv ====
// Gain set selection, bias, feed-forward and P-switching for the servo loops
`timescale 1ns/100ps
`default_nettype none
module sgb_top
  import sgb_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Operating mode and gain selection
  input wire logic [1:0] i_control_mode,
  input wire logic i_gain_select_input,
  input wire logic [3:0] i_gain_select_terminal_map,
  input wire logic [15:0] i_speed_control_setting_word,
  input wire logic i_pos_cmd_idle,
  input wire logic i_dev_in_switch_width,
  // Bias
  input wire logic [15:0] i_bias_speed,
  input wire logic [15:0] i_bias_band,
  input wire logic signed [15:0] i_residual_dev,
  input wire logic signed [15:0] i_speed_cmd,
  // Feed-forward
  input wire logic [15:0] i_feed_forward_amount,
  input wire logic [15:0] i_feed_forward_filter_time,
  input wire logic signed [15:0] i_ff_cmd,
  // P-switching quantities and thresholds
  input wire logic signed [15:0] i_torque_cmd,
  input wire logic signed [15:0] i_accel_cmd,
  input wire logic [15:0] i_p_switch_torque_threshold,
  input wire logic [15:0] i_p_switch_speed_threshold,
  input wire logic [15:0] i_p_switch_accel_threshold,
  input wire logic [15:0] i_p_switch_deviation_threshold,
  // Loop controls
  output logic o_second_gain_sel,
  output logic o_autotune_suspend,
  output logic o_ip_loop,
  output logic o_p_control,
  output logic o_ctrl_tick,
  // Commands to the loops
  output logic o_bias_active,
  output logic signed [16:0] o_speed_ref,
  output logic signed [16:0] o_ff_ref
);
  typedef struct packed {
    sgb_phase_t phase;
    logic [9:0] ctrl_cnt;
    logic tick;
    sgb_pcond_t pcond;
    sgb_loop_t loop;
    logic second;
    logic p_ctl;
    logic bias_on;
    logic signed [16:0] speed_ref;
  } sgb_state_t;

  localparam sgb_state_t STATE_RESET = '{
    phase: PH_LATCH,
    ctrl_cnt: CTRL_CNT_RESET,
    tick: 1'b0,
    pcond: sgb_pcond_t'(SPEED_WORD_RESET[WORD_PCOND_LSB +: 4]),
    loop: sgb_loop_t'(SPEED_WORD_RESET[WORD_LOOP_LSB]),
    second: 1'b0,
    p_ctl: 1'b0,
    bias_on: 1'b0,
    speed_ref: 17'sh00000
  };

  sgb_state_t st;
  sgb_state_t next_st;
  logic rst_meta;
  logic rst_n;
  logic chk_on;
  logic is_pos;
  logic [3:0] auto_sel;
  logic auto_on;
  logic auto_met;
  logic gain_select_input_on;
  logic [15:0] bias_spd;
  logic [15:0] bias_bnd;
  logic [15:0] dev_mag;
  logic [15:0] qty;
  logic [15:0] thr;
  logic signed [33:0] ff_prod;
  logic [15:0] ff_amt;

  sgb_ff_if ff_link ();

  // Reset enters asynchronously but is released on the clock
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
      chk_on <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
      // Checks wait one edge more: state still holds reset at release
      chk_on <= rst_n;
    end
  end

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    is_pos = (sgb_mode_t'(i_control_mode) == MODE_POSITION);
    auto_sel = i_speed_control_setting_word[WORD_AUTO_LSB +: 4];
    auto_on = (auto_sel == AUTO_CMD) || (auto_sel == AUTO_DEV) ||
              (auto_sel == AUTO_BOTH);
    case (sgb_auto_t'(auto_sel))
      AUTO_CMD: auto_met = i_pos_cmd_idle;
      AUTO_DEV: auto_met = i_dev_in_switch_width;
      AUTO_BOTH: auto_met = i_pos_cmd_idle && i_dev_in_switch_width;
      default: auto_met = 1'b0;
    endcase
    gain_select_input_on = (i_gain_select_terminal_map != GAIN_SELECT_INPUT_UNMAPPED) &&
              i_gain_select_input && !auto_on;
    // Restart-only fields are taken once, in the first cycle after release
    case (st.phase)
      PH_LATCH: begin
        if (i_speed_control_setting_word[WORD_PCOND_LSB +: 4] >
            PCOND_NONE) begin
          next_st.pcond = PCOND_NONE;
        end else begin
          next_st.pcond = sgb_pcond_t'(
            i_speed_control_setting_word[WORD_PCOND_LSB +: 4]);
        end
        next_st.loop = sgb_loop_t'(
          i_speed_control_setting_word[WORD_LOOP_LSB]);
        next_st.phase = PH_RUN;
      end
      PH_RUN: begin
        if (st.ctrl_cnt == CTRL_CNT_LAST) begin
          next_st.ctrl_cnt = CTRL_CNT_RESET;
          next_st.tick = 1'b1;
        end else begin
          next_st.ctrl_cnt = st.ctrl_cnt + 10'h001;
        end
      end
      default: next_st.phase = PH_LATCH;
    endcase
    next_st.second = (is_pos && auto_on && auto_met) || gain_select_input_on;
    bias_spd = sgb_sat(i_bias_speed, BIAS_SPEED_MAX);
    bias_bnd = sgb_sat(i_bias_band, BIAS_BAND_MAX);
    dev_mag = sgb_abs(i_residual_dev);
    next_st.bias_on = is_pos && (bias_spd != 16'h0000) &&
                      (dev_mag > bias_bnd);
    if (!next_st.bias_on) begin
      next_st.speed_ref = 17'(i_speed_cmd);
    end else if (i_residual_dev[15]) begin
      next_st.speed_ref = 17'(i_speed_cmd) - 17'(bias_spd);
    end else begin
      next_st.speed_ref = 17'(i_speed_cmd) + 17'(bias_spd);
    end
    case (st.pcond)
      PCOND_TORQUE: begin
        qty = sgb_abs(i_torque_cmd);
        thr = i_p_switch_torque_threshold;
      end
      PCOND_SPEED: begin
        qty = sgb_abs(i_speed_cmd);
        thr = i_p_switch_speed_threshold;
      end
      PCOND_ACCEL: begin
        qty = sgb_abs(i_accel_cmd);
        thr = i_p_switch_accel_threshold;
      end
      PCOND_DEV: begin
        qty = is_pos ? dev_mag : 16'h0000;
        thr = i_p_switch_deviation_threshold;
      end
      default: begin
        qty = 16'h0000;
        thr = 16'hffff;
      end
    endcase
    next_st.p_ctl = (st.phase == PH_RUN) && (qty > thr);
    ff_amt = sgb_sat(i_feed_forward_amount, FF_AMOUNT_MAX);
    ff_prod = 34'(i_ff_cmd) * $signed({18'h00000, ff_amt}) * FF_DIV_MUL;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Feed-forward only feeds the position loop; elsewhere it decays to zero
  assign ff_link.tick = st.tick;
  assign ff_link.time_const =
    13'(sgb_sat(i_feed_forward_filter_time, FF_TIME_MAX));
  assign ff_link.x = is_pos ? 17'(ff_prod >>> FF_DIV_SHIFT) : 17'sh00000;

  sgb_ff_filter u_filter (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .ff(ff_link.filt)
  );

  assign o_second_gain_sel = st.second;
  assign o_autotune_suspend = st.second || (st.loop == LOOP_IP);
  assign o_ip_loop = (st.loop == LOOP_IP);
  assign o_p_control = st.p_ctl;
  assign o_ctrl_tick = st.tick;
  assign o_bias_active = st.bias_on;
  assign o_speed_ref = st.speed_ref;
  assign o_ff_ref = ff_link.y;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!chk_on);

  sequence s_auto_pos;
    is_pos && auto_on && auto_met;
  endsequence

  sequence s_latch_then_run;
    st.phase == PH_LATCH ##1 st.phase == PH_RUN;
  endsequence

  AST_GAIN_SELECT_INPUT_SELECTS: assert property (
    is_pos && !auto_on &&
    i_gain_select_terminal_map != GAIN_SELECT_INPUT_UNMAPPED && i_gain_select_input
    |=> o_second_gain_sel)
    else $error("Mapped gain-select did not pick second set");
  AST_AUTO_SELECTS: assert property (
    s_auto_pos |=> o_second_gain_sel)
    else $error("Auto switching did not pick second set");
  AST_FIRST_OUTSIDE_POS: assert property (
    !is_pos && !(i_gain_select_input &&
    i_gain_select_terminal_map != GAIN_SELECT_INPUT_UNMAPPED) |=> !o_second_gain_sel)
    else $error("Second set used outside position control");
  AST_GAIN_SELECT_INPUT_IGNORED: assert property (
    auto_on && !auto_met
    |=> !o_second_gain_sel)
    else $error("Gain-select acted while auto switching enabled");
  AST_TUNE_SUSPEND: assert property (
    (is_pos && auto_on && auto_met) || (!auto_on && i_gain_select_input &&
    i_gain_select_terminal_map != GAIN_SELECT_INPUT_UNMAPPED)
    |=> o_autotune_suspend)
    else $error("Auto-tuning not suspended on second set");
  AST_BIAS_ADD: assert property (
    is_pos && i_bias_speed != 16'h0000 &&
    sgb_abs(i_residual_dev) > sgb_sat(i_bias_band, BIAS_BAND_MAX) &&
    !i_residual_dev[15] |=> o_bias_active &&
    o_speed_ref == $past(17'(i_speed_cmd)) +
    $past(17'(sgb_sat(i_bias_speed, BIAS_SPEED_MAX))))
    else $error("Bias speed not added outside the band");
  AST_BIAS_ZERO: assert property (
    i_bias_speed == 16'h0000
    |=> !o_bias_active && o_speed_ref == $past(17'(i_speed_cmd)))
    else $error("Zero bias speed still added bias");
  AST_PCOND_UNUSED: assert property (
    st.pcond == PCOND_NONE
    |=> !o_p_control)
    else $error("P control entered with switching unused");
  AST_PSWITCH_SPEED: assert property (
    st.phase == PH_RUN &&
    st.pcond == PCOND_SPEED &&
    sgb_abs(i_speed_cmd) > i_p_switch_speed_threshold
    |=> o_p_control)
    else $error("Speed command over threshold did not enter P");
  AST_RESTART_FIELDS: assert property (
    s_latch_then_run ##1 1
    |-> $stable(o_ip_loop)[*4])
    else $error("Restart-only loop type changed while running");
endmodule : sgb_top
`default_nettype wire

// ==== testbench/sgb_host_model.sv ====
// Host side: setting parameters and the external gain-select input
`timescale 1ns/100ps
`default_nettype none
module sgb_host_model (
  // Settings toward the drive
  output logic o_gain_select_input,
  output logic [3:0] o_map,
  output logic [15:0] o_word,
  output logic [15:0] o_bias,
  output logic [15:0] o_band,
  output logic [15:0] o_ff_amt,
  output logic [15:0] o_ff_time
);
  initial begin
    {o_gain_select_input, o_map, o_word} = {1'b0, 4'h0, 16'h0004};
    {o_bias, o_band, o_ff_amt, o_ff_time} = {16'h0, 16'h7, 16'h0, 16'h0};
  end

  task automatic put_gain(input logic g, input logic [3:0] m,
                          input logic [15:0] w);
    // Gain values stay host-side: first set motion, second standstill
    {o_gain_select_input, o_map, o_word} = {g, m, w};
  endtask : put_gain

  task automatic put_bias(input logic use_bias, input logic [15:0] s,
                          input logic [15:0] b);
    o_bias = use_bias ? s : 16'h0000;
    o_band = b;
  endtask : put_bias

  // Amounts above 80 are never sent, to spare the machine vibration
  task automatic put_ff(input logic [15:0] a, input logic [15:0] t);
    o_ff_amt = (a > 16'h0050) ? 16'h0050 : a;
    o_ff_time = t;
  endtask : put_ff
endmodule : sgb_host_model
`default_nettype wire

// ==== testbench/sgb_top_tb_top.sv ====
// Self-checking bench for the gain select, bias and P-switching block
`timescale 1ns/100ps
`default_nettype none
module sgb_top_tb_top
  import sgb_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [1:0] mode = 2'h0;
  logic idle = 1'b0, devw = 1'b0;
  logic signed [15:0] dev = 16'h0, spd = 16'h0, ffc = 16'h0;
  logic signed [15:0] tq = 16'h0, ac = 16'h0;
  logic [15:0] thr_t = 16'h0, thr_s = 16'h0, thr_a = 16'h0, thr_d = 16'h0;
  wire logic h_gain_select_input;
  wire logic [3:0] h_map;
  wire logic [15:0] h_word, h_bias, h_band, h_amt, h_time;
  logic sec, sus, ipl, pc, tick, bact;
  logic signed [16:0] sref, ffr;
  int n_mismatch = 0, compares = 0, cyc = 0;
  int lt, cnd, au, e, y, x, c;

  always #5 i_clk = ~i_clk;

  sgb_host_model sgb_host_model_i (.o_gain_select_input(h_gain_select_input), .o_map(h_map),
    .o_word(h_word), .o_bias(h_bias), .o_band(h_band),
    .o_ff_amt(h_amt), .o_ff_time(h_time));

  sgb_top sgb_top_i (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_control_mode(mode), .i_gain_select_input(h_gain_select_input),
    .i_gain_select_terminal_map(h_map),
    .i_speed_control_setting_word(h_word), .i_pos_cmd_idle(idle),
    .i_dev_in_switch_width(devw), .i_bias_speed(h_bias),
    .i_bias_band(h_band), .i_residual_dev(dev), .i_speed_cmd(spd),
    .i_feed_forward_amount(h_amt), .i_feed_forward_filter_time(h_time),
    .i_ff_cmd(ffc), .i_torque_cmd(tq), .i_accel_cmd(ac),
    .i_p_switch_torque_threshold(thr_t),
    .i_p_switch_speed_threshold(thr_s),
    .i_p_switch_accel_threshold(thr_a),
    .i_p_switch_deviation_threshold(thr_d),
    .o_second_gain_sel(sec), .o_autotune_suspend(sus), .o_ip_loop(ipl),
    .o_p_control(pc), .o_ctrl_tick(tick), .o_bias_active(bact),
    .o_speed_ref(sref), .o_ff_ref(ffr));

  task automatic wrap_up();
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Generous ceiling: eleven resets plus seven control cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  function automatic int mag(input int v);
    return v < 0 ? -v : v;
  endfunction : mag

  function automatic int exp_ref(input int b, input int bd);
    int bs;
    bs = b > 450 ? 450 : b;
    if (mode == 0 && mag(dev) > (bd > 250 ? 250 : bd))
      return spd + (dev < 0 ? -bs : bs);
    return spd;
  endfunction : exp_ref

  function automatic logic exp_sec(input int a);
    if (a >= 1 && a <= 3)
      return mode == 0 && (a == 1 ? idle : a == 2 ? devw : idle & devw);
    return h_map != 4'h0 && h_gain_select_input;
  endfunction : exp_sec

  function automatic logic exp_p();
    int q, t;
    q = cnd == 0 ? tq : cnd == 1 ? spd : cnd == 2 ? ac : dev;
    t = cnd == 0 ? thr_t : cnd == 1 ? thr_s : cnd == 2 ? thr_a : thr_d;
    return cnd < 4 && mag(q) > t && (cnd != 3 || mode == 0);
  endfunction : exp_p

  task automatic do_reset(input logic [15:0] w);
    @(negedge i_clk);
    i_arst_n = 1'b0;
    sgb_host_model_i.put_gain(1'b0, 4'h0, w);
    repeat (4) @(negedge i_clk);
    check({sec, pc, bact, ipl, 17'(sref)}, 32'h0);
    i_arst_n = 1'b1;
    repeat (4) @(negedge i_clk);
  endtask : do_reset

  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (tick !== 1'b1 && n < 1100);
  endtask : wait_tick

  initial begin
    void'($urandom(32'heb8f7867));
    for (int k = 0; k < 11; k++) begin
      // Last pass latches an undefined condition code, read as unused
      cnd = (k == 10) ? 15 : k % 5;
      lt = (k / 5) % 2;
      do_reset(16'(lt * 16 + cnd));
      check(32'(ipl), 32'(lt));
      for (int n = 0; n < 60; n++) begin
        mode = 2'($urandom % 4);
        au = $urandom % 5;
        {idle, devw} = 2'($urandom);
        if (au == 3 && n % 2 == 0) devw = idle;
        // Latched fields get junk to show later writes are ignored
        sgb_host_model_i.put_gain(1'($urandom), 4'($urandom % 3),
          16'(au * 256 + ($urandom % 2) * 16 + $urandom % 5));
        sgb_host_model_i.put_bias(($urandom % 4) != 0,
          16'($urandom % 600), 16'($urandom % 300));
        dev = 16'($signed($urandom % 1200) - 600);
        // Residual right on the band; the port wire has not settled yet
        if (n % 7 == 0) begin
          dev = sgb_host_model_i.o_band;
          if (n % 2) dev = -dev;
        end
        spd = 16'($signed($urandom % 4000) - 2000);
        tq = 16'($signed($urandom % 2000) - 1000);
        ac = 16'($signed($urandom % 2000) - 1000);
        {thr_t, thr_s} = {16'($urandom % 800), 16'($urandom % 800)};
        {thr_a, thr_d} = {16'($urandom % 800), 16'($urandom % 800)};
        @(negedge i_clk);
        check(32'(sec), 32'(exp_sec(au)));
        check(32'(sus), 32'(exp_sec(au) | lt[0]));
        e = exp_ref(h_bias, h_band);
        check(32'(sref), 32'(e));
        check(32'(bact), 32'(h_bias != 16'h0 && e != spd));
        check(32'(pc), 32'(exp_p()));
      end
    end
    wait_tick(c);
    @(negedge i_clk);
    y = 0;
    for (int i = 0; i < 6; i++) begin
      mode = (i == 1) ? 2'h1 : 2'h0;
      ffc = 16'($signed($urandom % 2000) - 1000);
      sgb_host_model_i.put_ff(16'($urandom % 81), (i < 3) ? 16'h0 : 16'h1);
      // Host copies are read: the port wires settle later in this step
      x = (mode == 0) ?
        (ffc * int'(sgb_host_model_i.o_ff_amt) * 655) >>> 16 : 0;
      y = (sgb_host_model_i.o_ff_time == 16'h0) ? x : y + ((x - y) >>> 1);
      wait_tick(c);
      check(32'(c + 1), 32'(CTRL_CYCLE_CLKS));
      @(negedge i_clk);
      check(32'(ffr), 32'(y));
    end
    wrap_up();
  end
endmodule : sgb_top_tb_top
`default_nettype wire
